// ### design/didr_pkg.sv
/*
  didr_pkg: register indexes, field positions and fixed values of the
  die identity readback block.
  assumes: byte address of a register is four times its index.
*/
package didr_pkg;

  // register indexes; byte address = index * 4
  localparam logic [7:0] DIDR_IDX_ID_0_15   = 8'h16;
  localparam logic [7:0] DIDR_IDX_ID_16_31  = 8'h17;
  localparam logic [7:0] DIDR_IDX_ID_32_47  = 8'h18;
  localparam logic [7:0] DIDR_IDX_ID_48_63  = 8'h19;
  localparam logic [7:0] DIDR_IDX_CHIP_TEST = 8'h7f;

  localparam int DIDR_ADDR_W = 12;
  localparam int DIDR_DATA_W = 32;
  localparam int DIDR_REG_W  = 16;
  localparam int DIDR_ID_W   = 64;

  // identity and level test register fields
  localparam int DIDR_LVL_HIGH_POS = 6;
  localparam int DIDR_LVL_LOW_POS  = 5;
  localparam int DIDR_MAKER_LSB    = 3;
  localparam int DIDR_REV_LSB      = 0;

  // arbitrary values, not those of any real part
  localparam logic [1:0] DIDR_MAKER_CODE = 2'h2;
  localparam logic [2:0] DIDR_REV_CODE   = 3'h4;

  localparam logic [DIDR_DATA_W-1:0] DIDR_RDATA_RST = 32'h0000_0000;

  typedef enum logic {DIDR_ST_IDLE, DIDR_ST_ACK} didr_state_t;

endpackage

// ### design/didr_rd_if.sv
/*
  didr_rd_if: read lookup path between the bus front end and the
  register read mux.
  assumes: purely combinational lookup, one index at a time.
*/
`timescale 1ns/1ps
interface didr_rd_if;
  logic [7:0]  idx;
  logic [31:0] data;
  logic        hit;

  modport req (output idx, input data, input hit);
  modport dec (input idx, output data, output hit);
endinterface

// ### design/didr_id_latch.sv
/*
  didr_id_latch: takes the 64-bit per-die word once, at the first edge
  after reset release.
  assumes: die_serial_bits_in is stable from reset release onward.
*/
`timescale 1ns/1ps
module didr_id_latch
#(
  parameter int ID_W = didr_pkg::DIDR_ID_W
)(
  // clock and reset
  input  wire logic            clk_in,
  input  wire logic            reset_in,
  // fuse side
  input  wire logic [ID_W-1:0] die_serial_bits_in,
  // captured word
  output logic      [ID_W-1:0] id_out,
  output logic                 loaded_out
);
  import didr_pkg::*;

  // a reset flop may only take a constant, so the word is caught after release
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      loaded_out <= 1'b0;
    end
    else
    begin
      loaded_out <= 1'b1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      id_out <= '0;
    end
    else if (!loaded_out)
    begin
      id_out <= die_serial_bits_in;
    end
  end

endmodule // didr_id_latch

// ### design/didr_reg_mux.sv
/*
  didr_reg_mux: read decode of the read-only identity registers.
  assumes: index arrives through didr_rd_if, answer used in same cycle.
*/
`timescale 1ns/1ps
module didr_reg_mux
(
  // captured die word
  input  wire logic [didr_pkg::DIDR_ID_W-1:0] id_in,
  // lookup port
  didr_rd_if.dec                              rd
);
  import didr_pkg::*;

  logic [DIDR_REG_W-1:0] chip_test;

  always_comb
  begin
    chip_test = '0;
    chip_test[DIDR_LVL_HIGH_POS] = 1'b1;
    chip_test[DIDR_LVL_LOW_POS] = 1'b0;
    chip_test[DIDR_MAKER_LSB +: 2] = DIDR_MAKER_CODE;
    chip_test[DIDR_REV_LSB +: 3] = DIDR_REV_CODE;
  end

  always_comb
  begin
    rd.hit  = 1'b1;
    rd.data = '0;
    unique case (rd.idx)
      DIDR_IDX_ID_0_15:   rd.data[15:0] = id_in[15:0];
      DIDR_IDX_ID_16_31:  rd.data[15:0] = id_in[31:16];
      DIDR_IDX_ID_32_47:  rd.data[15:0] = id_in[47:32];
      DIDR_IDX_ID_48_63:  rd.data[15:0] = id_in[63:48];
      DIDR_IDX_CHIP_TEST: rd.data[15:0] = chip_test;
      default:            rd.hit = 1'b0;
    endcase
  end

endmodule // didr_reg_mux

// ### design/didr_top.sv
/*
  didr_top: APB slave that returns the per-die identification word and
  the chip identity and level test register. All registers are read-only.
  assumes: APB3 master on clk_in, die word stable after reset release.
*/
// Implementation choice: the APB interface to the registers.
// Summary of operation
// - Index 0x16 returns die word bits 15:0 and writes to it change nothing.
// - Index 0x17 returns die word bits 31:16 and is read-only.
// - Index 0x18 returns die word bits 47:32 and is read-only.
// - Index 0x19 returns die word bits 63:48 and is read-only.
// - Bit 6 of index 0x7f always reads one, a fixed high output level.
// - Bit 5 of index 0x7f always reads zero, a fixed low output level.
`timescale 1ns/1ps
module didr_top
(
  // clock and reset
  input  wire logic                             clk_in,
  input  wire logic                             reset_in,
  // apb slave
  input  wire logic                             psel_in,
  input  wire logic                             penable_in,
  input  wire logic                             pwrite_in,
  input  wire logic [didr_pkg::DIDR_ADDR_W-1:0] paddr_in,
  input  wire logic [didr_pkg::DIDR_DATA_W-1:0] pwdata_in,
  output logic                                  pready_out,
  output logic      [didr_pkg::DIDR_DATA_W-1:0] prdata_out,
  output logic                                  pslverr_out,
  // die identity fuses
  input  wire logic [didr_pkg::DIDR_ID_W-1:0]   die_serial_bits_in
);
  import didr_pkg::*;

  // transfer state
  didr_state_t                state_q;
  didr_state_t                state_d;
  // captured die word
  logic [DIDR_ID_W-1:0]       id_word;
  logic                       id_loaded;
  // address checks
  logic                       addr_aligned;
  logic                       addr_in_page;
  logic                       addr_ok;
  // request qualifiers
  logic                       access;
  logic                       access_rd;
  // next values of the answer flops
  logic                       pready_d;
  logic [DIDR_DATA_W-1:0]     prdata_d;
  logic                       pslverr_d;
  // read lookup into the register mux
  didr_rd_if                  didr_rd_if_i ();

  didr_id_latch #(
    .ID_W               (DIDR_ID_W)
  ) didr_id_latch_i (
    .clk_in             (clk_in),
    .reset_in           (reset_in),
    .die_serial_bits_in (die_serial_bits_in),
    .id_out             (id_word),
    .loaded_out         (id_loaded)
  );

  didr_reg_mux didr_reg_mux_i (
    .id_in (id_word),
    .rd    (didr_rd_if_i)
  );

  // the word index; the mux says whether it names a register
  assign didr_rd_if_i.idx = paddr_in[9:2];

  // upper address bits and misaligned addresses fall outside the map
  always_comb
  begin
    addr_aligned = (paddr_in[1:0] == 2'h0);
    addr_in_page = (paddr_in[DIDR_ADDR_W-1:10] == '0);
    addr_ok      = didr_rd_if_i.hit && addr_aligned && addr_in_page;
  end

  // not answered until the word is caught; the state guard stops a second take
  // while the master still holds psel and penable in the answer cycle
  always_comb
  begin
    access    = psel_in && penable_in && id_loaded && (state_q == DIDR_ST_IDLE);
    access_rd = access && !pwrite_in;
  end

  // one wait state: the answer stands for exactly one cycle
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      DIDR_ST_IDLE:
      begin
        if (access)
        begin
          state_d = DIDR_ST_ACK;
        end
      end
      DIDR_ST_ACK:
      begin
        state_d = DIDR_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      state_q <= DIDR_ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  always_comb
  begin
    pready_d = access;
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      pready_out <= 1'b0;
    end
    else
    begin
      pready_out <= pready_d;
    end
  end

  // writes store nothing: every register here is read-only, so write data is ignored
  always_comb
  begin
    prdata_d = DIDR_RDATA_RST;
    if (access_rd && addr_ok)
    begin
      prdata_d = didr_rd_if_i.data;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      prdata_out <= DIDR_RDATA_RST;
    end
    else
    begin
      prdata_out <= prdata_d;
    end
  end

  // a write to a mapped register is taken silently; only unmapped addresses fail
  always_comb
  begin
    pslverr_d = 1'b0;
    if (access && !addr_ok)
    begin
      pslverr_d = 1'b1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      pslverr_out <= 1'b0;
    end
    else
    begin
      pslverr_out <= pslverr_d;
    end
  end

endmodule // didr_top

// ### dv/didr_top_asserts.sv
/*
  didr_top_asserts: checker on the ports of didr_top.
  assumes: die word is changed by the bench only while reset is held.
*/
`timescale 1ns/1ps
module didr_top_asserts
(
  input wire logic        clk_in,
  input wire logic        reset_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic [63:0] die_serial_bits_in
);
  import didr_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // address and direction of the access that the answer belongs to
  logic [11:0] a_q;
  logic        w_q;
  always_ff @(posedge clk_in)
  begin
    a_q <= paddr_in;
    w_q <= pwrite_in;
  end
  property p_id0; pready_out && !w_q && a_q == 12'h058
    |-> prdata_out == {16'h0, die_serial_bits_in[15:0]}; endproperty
  a_id0: assert property (p_id0) else $error("bits 15:0 wrong");
  property p_id1; pready_out && !w_q && a_q == 12'h05c
    |-> prdata_out == {16'h0, die_serial_bits_in[31:16]}; endproperty
  a_id1: assert property (p_id1) else $error("bits 31:16 wrong");
  property p_id2; pready_out && !w_q && a_q == 12'h060
    |-> prdata_out == {16'h0, die_serial_bits_in[47:32]}; endproperty
  a_id2: assert property (p_id2) else $error("bits 47:32 wrong");
  property p_id3; pready_out && !w_q && a_q == 12'h064
    |-> prdata_out == {16'h0, die_serial_bits_in[63:48]}; endproperty
  a_id3: assert property (p_id3) else $error("bits 63:48 wrong");
  // unmapped writes answer with an error, so only the data is checked for every write
  property p_wr; pready_out && w_q |-> prdata_out == 32'h0; endproperty
  a_wr: assert property (p_wr) else $error("write answer data wrong");
  property p_wr_ok; pready_out && w_q && a_q == 12'h058 |-> !pslverr_out; endproperty
  a_wr_ok: assert property (p_wr_ok) else $error("write to id raised error");
  property p_hi; pready_out && !w_q && a_q == 12'h1fc |-> prdata_out[6]; endproperty
  a_hi: assert property (p_hi) else $error("high bit low");
  property p_lo; pready_out && !w_q && a_q == 12'h1fc |-> !prdata_out[5]; endproperty
  a_lo: assert property (p_lo) else $error("low bit high");
  property p_err; pready_out && (a_q[1:0] != 2'h0 || a_q[11:10] != 2'h0)
    |-> pslverr_out && prdata_out == 32'h0; endproperty
  a_err: assert property (p_err) else $error("outside address not refused");
  property p_stand; pready_out |=> !pready_out; endproperty
  a_stand: assert property (p_stand) else $error("answer stood too long");
  property p_held; pready_out |-> psel_in && penable_in; endproperty
  a_held: assert property (p_held) else $error("answer outside a transfer");
  property p_code; pready_out && !w_q && a_q == 12'h1fc |-> prdata_out[31:7] == 25'h0
    && prdata_out[4:0] == {DIDR_MAKER_CODE, DIDR_REV_CODE}; endproperty
  a_code: assert property (p_code) else $error("code fields wrong");
  c_id: cover property (pready_out && !w_q && a_q == 12'h058);
  c_wr: cover property (pready_out && w_q);
  c_err: cover property (pready_out && pslverr_out);
  c_chip: cover property (pready_out && !w_q && a_q == 12'h1fc);
endmodule // didr_top_asserts

bind didr_top didr_top_asserts didr_top_asserts_i (
  .clk_in             (clk_in),
  .reset_in           (reset_in),
  .psel_in            (psel_in),
  .penable_in         (penable_in),
  .pwrite_in          (pwrite_in),
  .paddr_in           (paddr_in),
  .pwdata_in          (pwdata_in),
  .prdata_out         (prdata_out),
  .pready_out         (pready_out),
  .pslverr_out        (pslverr_out),
  .die_serial_bits_in (die_serial_bits_in)
);

// ### dv/didr_top_tb.sv
/*
  didr_top_tb: directed APB bench for didr_top.
  assumes: the master waits for pready, die word changed only in reset.
*/
`timescale 1ns/1ps
module didr_top_tb;
  import didr_pkg::*;
  logic        clk_in = 0, reset_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic [11:0] paddr_in = 0;
  logic [31:0] pwdata_in = 0, prdata_out, r;
  logic        pready_out, pslverr_out, e;
  logic [63:0] die_serial_bits_in = 64'hfedc_ba98_7654_3210;
  int          failures = 0, samples_checked = 0, cyc = 0;
  always #5 clk_in = ~clk_in;
  didr_top didr_top_i (
    .clk_in             (clk_in),
    .reset_in           (reset_in),
    .psel_in            (psel_in),
    .penable_in         (penable_in),
    .pwrite_in          (pwrite_in),
    .paddr_in           (paddr_in),
    .pwdata_in          (pwdata_in),
    .pready_out         (pready_out),
    .prdata_out         (prdata_out),
    .pslverr_out        (pslverr_out),
    .die_serial_bits_in (die_serial_bits_in)
  );
  task chk(input string s, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x)
    begin
      $display("Error %s expected %h seen %h", s, x, g);
      failures++;
    end
  endtask
  task test_done;
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // all-ones write data shows up at once if a write leaks into a register
  task xfer(input logic w, input logic [11:0] a);
    psel_in <= 1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= 32'hffff_ffff;
    @(posedge clk_in);
    penable_in <= 1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    r = prdata_out;
    e = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
    // one idle edge, so the next call never re-drives psel in this time step
    @(posedge clk_in);
  endtask
  task t_ids;
    for (int i = 0; i < 4; i++)
    begin
      xfer(0, 12'h058 + 12'(4 * i));
      chk("id", {16'h0, die_serial_bits_in[16*i +: 16]}, r);
    end
  endtask
  task t_wr;
    xfer(1, 12'h058);
    chk("werr", 32'h0, {31'h0, e});
    chk("wdat", 32'h0, r);
    xfer(0, 12'h058);
    chk("id0", {16'h0, die_serial_bits_in[15:0]}, r);
  endtask
  task t_idt;
    xfer(0, 12'h1fc);
    chk("hi", 32'h1, {31'h0, r[6]});
    chk("lo", 32'h0, {31'h0, r[5]});
    chk("up", 32'h0, {7'h0, r[31:7]});
    chk("code", {27'h0, DIDR_MAKER_CODE, DIDR_REV_CODE}, {27'h0, r[4:0]});
  endtask
  task t_bad;
    xfer(0, 12'h100);
    chk("err", 32'h1, {31'h0, e});
    chk("errd", 32'h0, r);
    xfer(0, 12'h05a);
    chk("mis", 32'h1, {31'h0, e});
    xfer(0, 12'h458);
    chk("page", 32'h1, {31'h0, e});
    chk("paged", 32'h0, r);
  endtask
  // second reset with a new die word: outputs quiet, new word caught after release
  task t_rst;
    reset_in <= 1;
    die_serial_bits_in <= 64'h0123_4567_89ab_cdef;
    repeat (3) @(posedge clk_in);
    chk("rst", 32'h0, {30'h0, pready_out, pslverr_out});
    chk("rstd", 32'h0, prdata_out);
    reset_in <= 0;
    xfer(0, 12'h064);
    chk("id3", {16'h0, die_serial_bits_in[63:48]}, r);
    xfer(0, 12'h058);
    chk("id0n", {16'h0, die_serial_bits_in[15:0]}, r);
  endtask
  always @(posedge clk_in)
    if (++cyc > 400)
    begin
      failures++;
      test_done;
    end
  initial
  begin
    repeat (3) @(posedge clk_in);
    reset_in <= 0;
    @(posedge clk_in);
    t_ids;
    t_wr;
    t_idt;
    t_bad;
    t_rst;
    test_done;
  end
endmodule // didr_top_tb
